// ===== bench/acs_chk.sv
`timescale 1ns/1ps
module acs_chk #(parameter int unsigned FWAKE_CYCLES = 40) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic conversion_start_n,
  input wire logic sleep_type_select,
  input wire logic busy,
  input wire logic [11:0] result_data_bus_o,
  input wire acs_pkg::acs_power_t power_ctl
);
  int cnt_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Busy cycles since last start fall
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !busy || $fell(conversion_start_n)) cnt_ff <= 0;
    else cnt_ff <= cnt_ff + 1;
  end
  chk_busy_len: assert property ($fell(busy) |-> cnt_ff == 220)
    else $error("busy length");
  chk_busy_cause: assert property ($rose(busy) |-> !$past(conversion_start_n))
    else $error("busy cause");
  chk_restart_hold: assert property ($fell(conversion_start_n) && busy |=> busy[*8])
    else $error("restart");
  chk_sleep_kind: assert property ($fell(busy) && !$past(conversion_start_n) |->
    power_ctl == ($past(sleep_type_select) ? 5'h06 : 5'h00)) else $error("sleep kind");
  chk_stay_awake: assert property ($fell(busy) && $past(conversion_start_n) |->
    power_ctl == 5'h1F) else $error("awake");
  chk_sleep_latch: assert property ((power_ctl == 5'h06 || power_ctl == 5'h00) &&
    !$rose(conversion_start_n) |=> $stable(power_ctl)) else $error("latch");
  chk_wake_power: assert property ($rose(conversion_start_n) && power_ctl != 5'h1F |->
    ##[1:2] power_ctl == 5'h1F) else $error("wake");
  chk_result_hold: assert property ($changed(result_data_bus_o) |-> $past(busy))
    else $error("result moved");
  cover property ($fell(conversion_start_n) && busy);
  cover property ($fell(busy) && power_ctl == 5'h06);
  cover property ($fell(busy) && power_ctl == 5'h00);
endmodule : acs_chk
bind acs_ctrl acs_chk #(.FWAKE_CYCLES(FWAKE_CYCLES)) u_acs_chk (.*);

// ===== bench/acs_host.sv
`timescale 1ns/1ps
module acs_host (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [11:0] bus,
  input wire logic oe,
  output logic start_n,
  output logic rd_n
);
  initial start_n = 1'b1;
  initial rd_n = 1'b1;
  // Start fall, held past busy to sleep
  task automatic conv(input bit hold);
    @(posedge clk_sys) start_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    start_n <= !hold;
  endtask : conv
  // Rise wakes, optional early fall
  task automatic wake(input bit fall);
    @(posedge clk_sys) start_n <= 1'b1;
    @(posedge clk_sys) start_n <= !fall;
  endtask : wake
  // Read strobe only while idle
  task automatic rd(output logic [11:0] d, output logic o);
    while (busy) @(negedge clk_sys);
    @(posedge clk_sys) rd_n <= 1'b0;
    @(posedge clk_sys) d = bus;
    o = oe;
    rd_n <= 1'b1;
  endtask : rd
endmodule : acs_host

// ===== bench/adc_conversion_sleep_control_bench.sv
`timescale 1ns/1ps
module adc_conversion_sleep_control_bench;
  logic clk_sys = 1'b0, rst_b = 1'b0, sel = 1'b1, sn, rd, busy, oe, rv, o;
  logic cs_n = 1'b0, rr = 1'b1;
  logic [11:0] code = 12'hA5C, bo, d;
  acs_pkg::acs_power_t pwr;
  int bad_count = 0, total_checks = 0, n;
  acs_ctrl #(.FWAKE_CYCLES(40)) u_acs_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
    .conversion_start_n(sn), .sleep_type_select(sel), .chip_select_n(cs_n), .read_n(rd),
    .sample_code(code), .result_ready(rr), .busy(busy), .result_data_bus_o(bo),
    .result_data_bus_oe(oe), .result_valid(rv), .power_ctl(pwr));
  acs_host u_acs_host (.clk_sys(clk_sys), .busy(busy), .bus(bo), .oe(oe), .start_n(sn),
    .rd_n(rd));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [11:0] g, e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask : chk
  // Cycles until busy reads v
  task automatic wt(input logic v);
    for (n = 0; busy !== v && n < 9999; n++) @(negedge clk_sys);
  endtask : wt
  task automatic results;
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Fast conversion, read, restart
  task automatic t_fast;
    u_acs_host.conv(1'b0);
    wt(1'b0);
    chk(12'(n), 12'h0DC);
    chk(12'(rv), 12'h001);
    chk(12'(pwr), 12'h01F);
    u_acs_host.rd(d, o);
    chk(d, 12'hA5C);
    chk(12'(o), 12'h001);
    @(posedge clk_sys) cs_n <= 1'b1;
    u_acs_host.rd(d, o);
    chk(12'(o), 12'h000);
    @(posedge clk_sys) cs_n <= 1'b0;
    rr <= 1'b0;
    repeat (35) @(posedge clk_sys);
    chk(12'(oe), 12'h000);
    u_acs_host.conv(1'b0);
    repeat (50) @(posedge clk_sys);
    u_acs_host.conv(1'b0);
    wt(1'b0);
    chk(12'(n), 12'h0DC);
    chk(12'(rv), 12'h000);
    rr <= 1'b1;
  endtask : t_fast
  // Sleep, latched type, deferred start
  task automatic t_sleep(input logic s, input logic [4:0] p, q, input int w);
    @(posedge clk_sys) sel <= s;
    u_acs_host.conv(1'b1);
    wt(1'b0);
    chk(12'(pwr), 12'(p));
    @(posedge clk_sys) sel <= !s;
    @(posedge clk_sys) code <= ~code;
    u_acs_host.rd(d, o);
    chk(12'(o), 12'h001);
    chk(12'(pwr), 12'(p));
    chk(d, ~code);
    u_acs_host.wake(1'b1);
    wt(1'b1);
    chk(12'(n > w - 4 && n < w + 4), 12'h001);
    wt(1'b0);
    chk(12'(pwr), 12'(q));
    u_acs_host.wake(1'b0);
    repeat (5000) @(posedge clk_sys);
    chk(12'(busy), 12'h000);
  endtask : t_sleep
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_fast();
    t_sleep(1'b1, 5'h06, 5'h00, 250);
    t_sleep(1'b0, 5'h00, 5'h06, 40);
    results();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule : adc_conversion_sleep_control_bench

// ===== rtl/acs_ctrl.sv
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_ctrl #(
  parameter int unsigned FWAKE_CYCLES = `ACS_FWAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic conversion_start_n,
  input wire logic sleep_type_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [`ACS_DATA_W-1:0] sample_code,
  input wire logic result_ready,
  output logic busy,
  output logic [`ACS_DATA_W-1:0] result_data_bus_o,
  output logic result_data_bus_oe,
  output logic result_valid,
  output acs_pkg::acs_power_t power_ctl
);
  import acs_pkg::*;

  // Sequencer state and shared interval counter
  acs_state_t state_ff;
  acs_state_t nxt_state;
  logic [`ACS_CNT_W-1:0] cnt_ff;
  logic [`ACS_CNT_W-1:0] nxt_cnt;

  // Start line history and its edges
  logic start_d_ff;
  logic fall;
  logic rise;

  // Sleep type and deferred start bookkeeping
  logic partial_ff;
  logic nxt_partial;
  logic pend_ff;
  logic nxt_pend;

  // Interval ends
  logic conv_done;
  logic conv_end;
  logic sleep_entry;
  logic wake_done;
  logic [`ACS_CNT_W-1:0] wake_last;

  // Output data register
  logic [`ACS_DATA_W-1:0] result_ff;

  // Two-entry result buffer, head is entry 0
  acs_word_t buf_ff [2];
  logic buf_vld_ff [2];
  acs_word_t shift_word [2];
  logic shift_vld [2];
  acs_word_t push_word;
  logic buf_in_rdy;
  logic buf_out_rdy;
  logic buf_push;
  logic buf_pop;
  logic push_slot;

  // Falling and rising edges of the start line
  assign fall = start_d_ff & ~conversion_start_n;
  assign rise = ~start_d_ff & conversion_start_n;

  // Start line history, idle high so reset gives no edge
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      start_d_ff <= 1'b1;
    end else begin
      start_d_ff <= conversion_start_n;
    end
  end

  // Last count of a conversion
  assign conv_done = (state_ff == ACS_CONV) && (cnt_ff == `ACS_CNT_W'(`ACS_CONV_CYC - 1));

  // Conversion ends only when the buffer can take the word
  assign conv_end = conv_done && buf_in_rdy;

  // Start still low at the end selects sleep
  assign sleep_entry = (state_ff == ACS_CONV) && (nxt_state == ACS_SLEEP);

  // Wake interval length depends on latched sleep type
  assign wake_last = partial_ff ? `ACS_CNT_W'(`ACS_PWAKE_CYC - 1)
                                : `ACS_CNT_W'(FWAKE_CYCLES - 1);
  assign wake_done = (state_ff == ACS_WAKE) && (cnt_ff >= wake_last);

  // Sequencer next state
  always_comb begin
    // Hold by default
    nxt_state = state_ff;
    unique case (state_ff)
      ACS_ACQ: begin
        // Acquiring, armed for a start edge
        if (fall) begin
          nxt_state = ACS_CONV;
        end
      end
      ACS_CONV: begin
        // A restart edge wins over the end
        if (!fall && conv_end) begin
          nxt_state = conversion_start_n ? ACS_ACQ : ACS_SLEEP;
        end
      end
      ACS_SLEEP: begin
        // Only a rising start edge wakes
        if (rise) begin
          nxt_state = ACS_WAKE;
        end
      end
      ACS_WAKE: begin
        // Deferred start begins here
        if (wake_done) begin
          nxt_state = (pend_ff || fall) ? ACS_CONV : ACS_ACQ;
        end
      end
      default: begin
        nxt_state = ACS_ACQ;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= ACS_ACQ;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Interval counter next value
  always_comb begin
    // Count up by default
    nxt_cnt = cnt_ff + `ACS_CNT_W'(1);
    unique case (state_ff)
      ACS_ACQ: begin
        nxt_cnt = '0;
      end
      ACS_CONV: begin
        if (fall) begin
          nxt_cnt = '0;
        end else if (conv_done) begin
          // Hold the last count while the buffer is full
          nxt_cnt = buf_in_rdy ? '0 : cnt_ff;
        end
      end
      ACS_SLEEP: begin
        nxt_cnt = '0;
      end
      ACS_WAKE: begin
        // Wake interval restarts the count at its end
        if (wake_done) begin
          nxt_cnt = '0;
        end
      end
      default: begin
        nxt_cnt = '0;
      end
    endcase
  end

  // Interval counter, times conversion and wake-up
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Deferred start memory next value
  always_comb begin
    nxt_pend = pend_ff;
    if (state_ff != ACS_WAKE) begin
      nxt_pend = 1'b0;
    end else if (fall) begin
      nxt_pend = 1'b1;
    end else if (rise) begin
      nxt_pend = 1'b0;
    end
  end

  // Start edge seen during wake-up
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // Sleep type next value, taken only on entry
  always_comb begin
    nxt_partial = partial_ff;
    if (sleep_entry) begin
      nxt_partial = sleep_type_select;
    end
  end

  // Latched sleep type
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      partial_ff <= 1'b0;
    end else begin
      partial_ff <= nxt_partial;
    end
  end

  // Output register, loaded on conv_end, also when a restart edge in that cycle keeps busy high
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      result_ff <= `ACS_RESULT_RST;
    end else if (conv_end) begin
      result_ff <= sample_code;
    end
  end

  // Buffer input side
  assign buf_in_rdy = ~buf_vld_ff[1];
  assign buf_push = conv_end && result_ready;
  assign push_word.data = sample_code;

  // Buffer output side, output register always takes
  assign buf_out_rdy = 1'b1;
  assign buf_pop = buf_vld_ff[0] && buf_out_rdy;

  // First free slot after the pop
  assign push_slot = shift_vld[0];

  // Per-entry shift, load and storage
  for (genvar gi = 0; gi < 2; gi++) begin : g_buf
    logic up_vld;
    acs_word_t up_word;
    logic take;
    logic nxt_vld;
    acs_word_t nxt_word;

    // Neighbour above, empty past the top entry
    if (gi == 1) begin : g_top
      assign up_vld = 1'b0;
      assign up_word = '0;
    end else begin : g_low
      assign up_vld = buf_vld_ff[gi+1];
      assign up_word = buf_ff[gi+1];
    end

    // Move down on a pop
    assign shift_vld[gi] = buf_pop ? up_vld : buf_vld_ff[gi];
    assign shift_word[gi] = buf_pop ? up_word : buf_ff[gi];

    // New word lands in the first free slot
    assign take = buf_push && (push_slot == 1'(gi));
    assign nxt_vld = shift_vld[gi] | take;
    assign nxt_word = take ? push_word : shift_word[gi];

    // Entry storage
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        buf_vld_ff[gi] <= 1'b0;
        buf_ff[gi] <= '0;
      end else begin
        buf_vld_ff[gi] <= nxt_vld;
        buf_ff[gi] <= nxt_word;
      end
    end
  end

  // Busy only while converting
  assign busy = (state_ff == ACS_CONV);
  // Head valid flag
  assign result_valid = buf_vld_ff[0];
  // Held result
  assign result_data_bus_o = result_ff;

  // Bus drive only while selected and read
  assign result_data_bus_oe = ~chip_select_n & ~read_n;

  // Power controls per state
  always_comb begin
    power_ctl = '1;
    unique case (state_ff)
      ACS_SLEEP: begin
        // Oscillator stops in either sleep
        power_ctl.osc_on = 1'b0;
        // Comparator off and reference buffer in low power
        power_ctl.comparator_on = 1'b0;
        power_ctl.refbuf_full_power = 1'b0;
        // Full sleep also drops buffer and reference
        power_ctl.refbuf_on = partial_ff;
        power_ctl.reference_on = partial_ff;
      end
      ACS_ACQ, ACS_CONV, ACS_WAKE: begin
        // Fully powered while awake or waking
        power_ctl = '1;
      end
      default: begin
        power_ctl = '1;
      end
    endcase
  end
endmodule : acs_ctrl

// ===== rtl/acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_CLK_PS 4000
`define ACS_CONV_NS 880
`define ACS_CONV_CYC ((`ACS_CONV_NS * 1000) / `ACS_CLK_PS)
`define ACS_PWAKE_US 1
`define ACS_PWAKE_CYC ((`ACS_PWAKE_US * 1000000 + `ACS_CLK_PS - 1) / `ACS_CLK_PS)
`define ACS_FWAKE_US 500
`define ACS_FWAKE_CYC ((`ACS_FWAKE_US * 1000000 + `ACS_CLK_PS - 1) / `ACS_CLK_PS)
`define ACS_DATA_W 12
`define ACS_CNT_W 18
`define ACS_RESULT_RST 12'h000
`endif

// ===== rtl/acs_pkg.sv
`include "acs_params.svh"
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_ACQ = 3'b000,
    ACS_CONV = 3'b001,
    ACS_SLEEP = 3'b011,
    ACS_WAKE = 3'b010
  } acs_state_t;
  typedef struct packed {
    logic comparator_on;
    logic refbuf_full_power;
    logic refbuf_on;
    logic reference_on;
    logic osc_on;
  } acs_power_t;
  typedef struct packed {
    logic [`ACS_DATA_W-1:0] data;
  } acs_word_t;
endpackage : acs_pkg
